/* sector_protect_sequencer.sv */
`timescale 1ns/1ps
`include "sps_consts.svh"
module sector_protect_sequencer #(
    parameter int GROUPS = 18,
    parameter logic [21:0] GROUP_STRIDE = 22'h040000,
    parameter int UNPROTECT_COM_CYC = `SPS_CYC_MS(`SPS_UNPROTECT_COM_MS),
    parameter int UNPROTECT_IND_CYC = `SPS_CYC_MS(`SPS_UNPROTECT_IND_MS),
    parameter int PROTECT_WAIT_CYC = `SPS_CYC_US(`SPS_PROTECT_WAIT_US),
    parameter int READY_SPAN_CYC = `SPS_CYC_US(`SPS_READY_SPAN_US)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic startProtect,
    input wire logic startUnprotect,
    input wire logic startHwReset,
    input wire logic embeddedBusy,
    input wire logic industrial,
    input wire logic [GROUPS-1:0] groupMask,
    input wire logic [7:0] dqIn,
    output logic [21:0] flashAddr,
    output logic [7:0] dqOut,
    output logic dqOe,
    output logic ceN,
    output logic oeN,
    output logic weN,
    output logic resetN,
    output logic resetElevated,
    output logic busy,
    output logic done,
    output logic failed,
    output logic [9:0] pulseAttemptCount
);
    import sps_pkg::*;
    // ns figures round up to whole cycles so no wait falls short
    localparam int RST_SPAN_CYC = `SPS_CYC_US(`SPS_RESET_PULSE_SPAN_US);
    localparam int RST_IDLE_CYC = `SPS_CYC_NS(`SPS_RESET_PULSE_IDLE_NS);
    localparam int READY_IDLE_CYC = `SPS_CYC_NS(`SPS_READY_IDLE_NS);
    localparam int SETTLE_CYC = `SPS_CYC_US(`SPS_ELEVATED_SETTLE_US);
    localparam int GW = (GROUPS > 1) ? $clog2(GROUPS) : 1;

    sps_state_e state, next_state;
    // one shared down-counter; 32 bits keeps the longest wait safe at faster clocks
    logic [31:0] timer, next_timer;
    logic [9:0] next_pulseAttemptCount;
    logic [GW-1:0] group, next_group;
    logic doUnprotect, next_doUnprotect;
    logic recovering, next_recovering;
    logic next_resetN, next_resetElevated, next_busy, next_done, next_failed;
    // issued stops a waiting state from starting a second bus access
    logic issued, next_issued;
    sps_op_e op;
    sps_bus_s req;
    logic cycBusy, cycDone;
    logic [7:0] rdData;

    // equal group stride assumed: with 18 groups of 256K bytes the last two
    // wrap past the 22-bit address, so an uneven group map needs its own table
    // A6 picks chip unprotect, A1/A0 fixed at 1/0 on every pulse and verify
    function automatic logic [21:0] cmdAddr(input logic [GW-1:0] g, input logic a6);
        logic [21:0] a;
        a = 22'(g) * GROUP_STRIDE;
        a[`SPS_BIT_A6] = a6;
        a[`SPS_BIT_A1] = 1'b1;
        a[`SPS_BIT_A0] = 1'b0;
        return a;
    endfunction

    // next group still needing a protect pulse, or GROUPS when none is left
    function automatic logic [GW:0] nextUnprot(input logic [GW:0] from);
        logic [GW:0] r;
        r = (GW+1)'(GROUPS);
        for (int i = GROUPS - 1; i >= 0; i--) begin
            if ((GW+1)'(i) >= from && !groupMask[i]) begin
                r = (GW+1)'(i);
            end
        end
        return r;
    endfunction

    sps_bus_cycle uCycle (
        .clk(clk),
        .rst_n(rst_n),
        .op(op),
        .req(req),
        .dqIn(dqIn),
        .busy(cycBusy),
        .done(cycDone),
        .rdData(rdData),
        .addr(flashAddr),
        .dqOut(dqOut),
        .dqOe(dqOe),
        .ceN(ceN),
        .oeN(oeN),
        .weN(weN)
    );

    always_comb begin
        logic [GW:0] nu;
        nu = '0;
        next_state = state;
        next_timer = (timer != 32'h0) ? timer - 32'h1 : 32'h0;
        next_pulseAttemptCount = pulseAttemptCount;
        next_group = group;
        next_doUnprotect = doUnprotect;
        next_recovering = recovering;
        next_resetN = resetN;
        next_resetElevated = resetElevated;
        next_busy = busy;
        next_done = 1'b0;
        next_failed = failed;
        next_issued = issued;
        op = SPS_OP_IDLE;
        req = '{addr: 22'h000000, data: 8'h00};
        unique case (state)
            SPS_IDLE: begin
                if (startHwReset) begin
                    next_state = SPS_HWRST;
                    next_resetN = 1'b0;
                    next_recovering = 1'b0;
                    next_busy = 1'b1;
                    next_timer = embeddedBusy ? 32'(RST_SPAN_CYC) : 32'(RST_IDLE_CYC);
                end else if (startProtect || startUnprotect) begin
                    next_state = SPS_RAISE;
                    next_doUnprotect = startUnprotect;
                    next_pulseAttemptCount = 10'h001;
                    next_resetElevated = 1'b1;
                    next_timer = 32'(SETTLE_CYC);
                    next_busy = 1'b1;
                    next_failed = 1'b0;
                end
            end
            SPS_HWRST: begin
                if (timer == 32'h0) begin
                    if (!recovering) begin
                        // device ready time runs from the rising edge; span is the safe worst case
                        next_resetN = 1'b1;
                        next_recovering = 1'b1;
                        next_timer = embeddedBusy ? 32'(READY_SPAN_CYC) : 32'(READY_IDLE_CYC);
                    end else begin
                        next_state = SPS_DONE;
                    end
                end
            end
            SPS_RAISE: begin
                if (timer == 32'h0) begin
                    nu = nextUnprot('0);
                    // a first write of anything but 60h would drop the part into temporary unprotect
                    if (nu != (GW+1)'(GROUPS)) begin
                        next_group = nu[GW-1:0];
                        next_state = SPS_PPULSE;
                    end else if (doUnprotect) begin
                        next_group = '0;
                        next_state = SPS_UPULSE;
                    end else begin
                        next_state = SPS_DROP;
                    end
                end
            end
            SPS_PPULSE, SPS_PVCMD, SPS_UPULSE, SPS_UVCMD, SPS_RSTCMD: begin
                if (!issued && !cycBusy) begin
                    op = SPS_OP_WRITE;
                    next_issued = 1'b1;
                    unique case (state)
                        SPS_PPULSE: req = '{addr: cmdAddr(group, 1'b0), data: `SPS_CMD_PULSE};
                        SPS_PVCMD: req = '{addr: cmdAddr(group, 1'b0), data: `SPS_CMD_VERIFY};
                        SPS_UPULSE: req = '{addr: cmdAddr(group, 1'b1), data: `SPS_CMD_PULSE};
                        SPS_UVCMD: req = '{addr: cmdAddr(group, 1'b1), data: `SPS_CMD_VERIFY};
                        default: req = '{addr: 22'h000000, data: `SPS_CMD_RESET};
                    endcase
                end else if (cycDone) begin
                    next_issued = 1'b0;
                    unique case (state)
                        SPS_PPULSE: begin
                            next_state = SPS_PWAIT;
                            next_timer = 32'(PROTECT_WAIT_CYC);
                        end
                        SPS_UPULSE: begin
                            next_state = SPS_UWAIT;
                            next_timer = industrial ? 32'(UNPROTECT_IND_CYC)
                                                    : 32'(UNPROTECT_COM_CYC);
                        end
                        SPS_PVCMD: next_state = SPS_PVREAD;
                        SPS_UVCMD: next_state = SPS_UVREAD;
                        default: begin
                            next_state = SPS_DONE;
                        end
                    endcase
                end
            end
            SPS_PWAIT: if (timer == 32'h0) next_state = SPS_PVCMD;
            SPS_UWAIT: if (timer == 32'h0) next_state = SPS_UVCMD;
            SPS_PVREAD, SPS_UVREAD: begin
                if (!issued && !cycBusy) begin
                    op = SPS_OP_READ;
                    next_issued = 1'b1;
                    req = '{addr: cmdAddr(group, state == SPS_UVREAD), data: 8'h00};
                end else if (cycDone) begin
                    next_issued = 1'b0;
                    if (state == SPS_PVREAD) begin
                        if (rdData == `SPS_DATA_PROTECTED) begin
                            // a passing verify restarts the count for the next group
                            nu = nextUnprot((GW+1)'(group) + (GW+1)'(1));
                            next_pulseAttemptCount = 10'h001;
                            if (nu != (GW+1)'(GROUPS)) begin
                                next_group = nu[GW-1:0];
                                next_state = SPS_PPULSE;
                            end else if (doUnprotect) begin
                                next_group = '0;
                                next_state = SPS_UPULSE;
                            end else begin
                                next_state = SPS_DROP;
                            end
                        end else if (pulseAttemptCount == 10'(`SPS_PROTECT_MAX)) begin
                            next_state = SPS_FAIL;
                        end else begin
                            next_pulseAttemptCount = pulseAttemptCount + 10'h001;
                            next_state = SPS_PPULSE;
                        end
                    end else begin
                        if (rdData == `SPS_DATA_UNPROTECTED) begin
                            // one chip pulse clears every group, so later groups are only verified
                            next_pulseAttemptCount = 10'h001;
                            if (group == GW'(GROUPS - 1)) begin
                                next_state = SPS_DROP;
                            end else begin
                                next_group = group + GW'(1);
                                next_state = SPS_UVCMD;
                            end
                        end else if (pulseAttemptCount == 10'(`SPS_UNPROTECT_MAX)) begin
                            next_state = SPS_FAIL;
                        end else begin
                            next_pulseAttemptCount = pulseAttemptCount + 10'h001;
                            next_state = SPS_UPULSE;
                        end
                    end
                end
            end
            // the reset command waits a cycle so the pin leaves the elevated level first
            SPS_DROP: begin
                next_resetElevated = 1'b0;
                next_state = SPS_RSTCMD;
            end
            SPS_FAIL: begin
                // elevated level is dropped so the part is not left in a protect mode
                next_resetElevated = 1'b0;
                next_failed = 1'b1;
                next_busy = 1'b0;
                next_done = 1'b1;
                next_state = SPS_IDLE;
            end
            SPS_DONE: begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_state = SPS_IDLE;
            end
            default: next_state = SPS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SPS_IDLE;
            timer <= 32'h0;
            pulseAttemptCount <= 10'h001;
            group <= '0;
            doUnprotect <= 1'b0;
            recovering <= 1'b0;
            resetN <= 1'b1;
            resetElevated <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            failed <= 1'b0;
            issued <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            pulseAttemptCount <= next_pulseAttemptCount;
            group <= next_group;
            doUnprotect <= next_doUnprotect;
            recovering <= next_recovering;
            resetN <= next_resetN;
            resetElevated <= next_resetElevated;
            busy <= next_busy;
            done <= next_done;
            failed <= next_failed;
            issued <= next_issued;
        end
    end
endmodule

/* sector_protect_sequencer_test.sv */
`timescale 1ns/1ps
module sector_protect_sequencer_test;
    logic clk = 0, rst_n = 0, startProtect = 0, startUnprotect = 0, startHwReset = 0;
    logic embeddedBusy = 0, industrial = 0, stuckProtect = 0, stuckUnprotect = 0;
    logic [3:0] groupMask = 4'h0;
    logic [7:0] dqIn, dqOut;
    logic [21:0] flashAddr;
    logic dqOe, ceN, oeN, weN, resetN, resetElevated, busy, done, failed;
    logic [9:0] pulseAttemptCount;
    int errCount = 0, compares = 0;
    always #10 clk = ~clk;
    // short waits keep the thousand-pulse run inside the cycle budget
    sector_protect_sequencer #(.GROUPS(4), .PROTECT_WAIT_CYC(20), .UNPROTECT_COM_CYC(20),
        .UNPROTECT_IND_CYC(30), .READY_SPAN_CYC(30)) uut (.clk(clk), .rst_n(rst_n),
        .startProtect(startProtect), .startUnprotect(startUnprotect),
        .startHwReset(startHwReset), .embeddedBusy(embeddedBusy), .industrial(industrial),
        .groupMask(groupMask), .dqIn(dqIn), .flashAddr(flashAddr), .dqOut(dqOut),
        .dqOe(dqOe), .ceN(ceN), .oeN(oeN), .weN(weN), .resetN(resetN),
        .resetElevated(resetElevated), .busy(busy), .done(done), .failed(failed),
        .pulseAttemptCount(pulseAttemptCount));
    sps_flash_model #(.PROT_NS(400.0), .COM_NS(400.0), .IND_NS(600.0)) mdl (.addr(flashAddr),
        .dqOut(dqOut), .ceN(ceN), .oeN(oeN), .weN(weN), .resetN(resetN),
        .resetElevated(resetElevated), .industrial(industrial), .stuckProtect(stuckProtect),
        .stuckUnprotect(stuckUnprotect), .dqIn(dqIn));
    task automatic finishTest();
        $display("compares %0d mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic runOp(input logic [1:0] which);
        int n;
        startHwReset <= (which == 2'h0);
        startProtect <= (which == 2'h1);
        startUnprotect <= (which == 2'h2);
        @(posedge clk);
        startHwReset <= 1'b0;
        startProtect <= 1'b0;
        startUnprotect <= 1'b0;
        @(negedge clk);
        check("busy", busy, 1);
        n = 0;
        while (done !== 1'b1 && n < 100000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100000) begin
            check("done", done, 1);
            finishTest();
        end
    endtask
    task automatic testHwReset(input logic emb, input real minNs);
        @(posedge clk);
        embeddedBusy <= emb;
        runOp(2'h0);
        check("reset low width", mdl.lowNs >= minNs, 1);
        $display("hardware reset test done");
    endtask
    task automatic testProtect(input logic [3:0] mask, input logic stuck,
        input logic [3:0] expProt, input int expPulses, input logic expFail);
        @(posedge clk);
        groupMask <= mask;
        stuckProtect <= stuck;
        runOp(2'h1);
        check("failed", failed, expFail);
        if (expFail) check("attempt count", pulseAttemptCount, 10'h019);
        check("pulses", mdl.pulses, expPulses);
        check("group state", mdl.prot, expProt);
        check("temporary mode", mdl.tempMode, 0);
        check("device faults", mdl.errs, 0);
        check("reset command", mdl.rstCmd, !expFail);
        check("elevated level", resetElevated, 0);
        $display("protect test done");
    endtask
    task automatic testUnprotect(input logic ind, input logic stuck,
        input logic [3:0] expProt, input int expPulses, input logic expFail);
        @(posedge clk);
        groupMask <= 4'h0;
        stuckProtect <= 1'b0;
        industrial <= ind;
        stuckUnprotect <= stuck;
        runOp(2'h2);
        check("failed", failed, expFail);
        if (expFail) check("attempt count", pulseAttemptCount, 10'h3E8);
        check("pulses", mdl.pulses, expPulses);
        check("group state", mdl.prot, expProt);
        check("device faults", mdl.errs, 0);
        check("reset command", mdl.rstCmd, !expFail);
        $display("unprotect test done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        testHwReset(1'b0, 500.0);
        testHwReset(1'b1, 10000.0);
        testProtect(4'h2, 1'b0, 4'hD, 3, 1'b0);
        testProtect(4'hD, 1'b1, 4'hD, 25, 1'b1);
        testUnprotect(1'b0, 1'b0, 4'h0, 5, 1'b0);
        testUnprotect(1'b1, 1'b0, 4'h0, 5, 1'b0);
        testUnprotect(1'b0, 1'b1, 4'hF, 1004, 1'b1);
        finishTest();
    end
endmodule

/* sps_bus_cycle.sv */
`timescale 1ns/1ps
`include "sps_consts.svh"
module sps_bus_cycle (
    input wire logic clk,
    input wire logic rst_n,
    input wire sps_pkg::sps_op_e op,
    input wire sps_pkg::sps_bus_s req,
    input wire logic [7:0] dqIn,
    output logic busy,
    output logic done,
    output logic [7:0] rdData,
    output logic [21:0] addr,
    output logic [7:0] dqOut,
    output logic dqOe,
    output logic ceN,
    output logic oeN,
    output logic weN
);
    import sps_pkg::*;
    // four 20 ns cycles per access covers the slowest grade's cycle time
    logic [2:0] cnt, next_cnt;
    logic isRead, next_isRead;
    logic next_busy, next_done, next_dqOe, next_ceN, next_oeN, next_weN;
    logic [21:0] next_addr;
    logic [7:0] next_dqOut, next_rdData;
    always_comb begin
        next_cnt = cnt;
        next_isRead = isRead;
        next_busy = busy;
        next_done = 1'b0;
        next_addr = addr;
        next_dqOut = dqOut;
        next_rdData = rdData;
        next_dqOe = dqOe;
        next_ceN = ceN;
        next_oeN = oeN;
        next_weN = weN;
        if (!busy) begin
            if (op != SPS_OP_IDLE) begin
                next_busy = 1'b1;
                next_cnt = 3'h0;
                next_isRead = (op == SPS_OP_READ);
                next_addr = req.addr;
                next_dqOut = req.data;
                next_dqOe = (op == SPS_OP_WRITE);
                next_ceN = 1'b0;
            end
        end else begin
            next_cnt = cnt + 3'h1;
            if (cnt == 3'h0) begin
                next_weN = isRead;
                next_oeN = !isRead;
            end
            if (cnt == 3'(`SPS_BUS_CYCLES - 1)) begin
                next_weN = 1'b1;
                next_oeN = 1'b1;
                next_ceN = 1'b1;
                next_rdData = dqIn;
            end
            if (cnt == 3'(`SPS_BUS_CYCLES)) begin
                next_dqOe = 1'b0;
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            isRead <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            addr <= 22'h000000;
            dqOut <= 8'h00;
            rdData <= 8'h00;
            dqOe <= 1'b0;
            ceN <= 1'b1;
            oeN <= 1'b1;
            weN <= 1'b1;
        end else begin
            cnt <= next_cnt;
            isRead <= next_isRead;
            busy <= next_busy;
            done <= next_done;
            addr <= next_addr;
            dqOut <= next_dqOut;
            rdData <= next_rdData;
            dqOe <= next_dqOe;
            ceN <= next_ceN;
            oeN <= next_oeN;
            weN <= next_weN;
        end
    end
endmodule

/* sps_consts.svh */
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
`define SPS_CLK_MHZ 50
`define SPS_RESET_PULSE_SPAN_US 10
`define SPS_RESET_PULSE_IDLE_NS 500
`define SPS_READY_SPAN_US 20
`define SPS_READY_IDLE_NS 500
`define SPS_ELEVATED_SETTLE_US 1
`define SPS_PROTECT_WAIT_US 150
`define SPS_UNPROTECT_COM_MS 15
`define SPS_UNPROTECT_IND_MS 18
`define SPS_CYC_US(x) ((x) * `SPS_CLK_MHZ)
`define SPS_CYC_NS(x) (((x) * `SPS_CLK_MHZ + 999) / 1000)
`define SPS_CYC_MS(x) ((x) * 1000 * `SPS_CLK_MHZ)
`define SPS_CMD_PULSE 8'h60
`define SPS_CMD_VERIFY 8'h40
`define SPS_CMD_RESET 8'hF0
`define SPS_DATA_PROTECTED 8'h01
`define SPS_DATA_UNPROTECTED 8'h00
`define SPS_PROTECT_MAX 25
`define SPS_UNPROTECT_MAX 1000
`define SPS_BIT_A6 6
`define SPS_BIT_A1 1
`define SPS_BIT_A0 0
`define SPS_BUS_CYCLES 4
`endif

/* sps_flash_model.sv */
`timescale 1ns/1ps
// behavioural device; only four groups modelled, group index from addr[21:18]
module sps_flash_model #(
    parameter real PROT_NS = 400.0,
    parameter real COM_NS = 400.0,
    parameter real IND_NS = 600.0
) (
    input wire logic [21:0] addr,
    input wire logic [7:0] dqOut,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic resetN,
    input wire logic resetElevated,
    input wire logic industrial,
    input wire logic stuckProtect,
    input wire logic stuckUnprotect,
    output logic [7:0] dqIn
);
    logic [3:0] prot = 4'h0;
    logic tempMode = 0, firstWr = 0, rstCmd = 0, verifying = 0;
    logic [7:0] outVal = 8'hFF;
    int pulses = 0, errs = 0, lastG = 0;
    realtime lowStart = 0, lowNs = 0, elevAt = 0, pulseAt = 0;
    // released bus shows the inverse so a late sample cannot pass by luck
    assign dqIn = (!ceN && !oeN) ? outVal : ~outVal;
    always @(negedge resetN) lowStart = $realtime;
    always @(posedge resetN) lowNs = $realtime - lowStart;
    always @(posedge resetElevated) begin
        elevAt = $realtime;
        firstWr = 1;
        pulses = 0;
        rstCmd = 0;
        lastG = 0;
        tempMode = 0;
    end
    always @(negedge oeN) outVal = verifying ? {7'h00, prot[addr[21:18]]} : 8'hFF;
    always @(posedge weN) begin
        if (!resetN) begin
            errs++;
        end else if (resetElevated) begin
            if (firstWr && ($realtime - elevAt < 1000.0)) errs++;
            if (firstWr && dqOut !== 8'h60) tempMode = 1;
            firstWr = 0;
            verifying = (dqOut === 8'h40);
            if (dqOut === 8'h60 && addr[1:0] === 2'b10) begin
                pulses++;
                pulseAt = $realtime;
                if (!addr[6] && !stuckProtect) prot[addr[21:18]] = 1;
                if (addr[6] && prot !== 4'hF) errs++;
                if (addr[6] && !stuckUnprotect) prot = 4'h0;
            end else if (verifying) begin
                if ($realtime - pulseAt < (addr[6] ? (industrial ? IND_NS : COM_NS) : PROT_NS))
                    errs++;
                if (addr[6] && int'(addr[21:18]) < lastG) errs++;
                if (addr[6]) lastG = int'(addr[21:18]);
            end
        end else if (dqOut === 8'hF0) begin
            rstCmd = 1;
        end
    end
endmodule

/* sps_pkg.sv */
package sps_pkg;
    typedef enum logic [1:0] {
        SPS_OP_IDLE = 2'b00,
        SPS_OP_WRITE = 2'b01,
        SPS_OP_READ = 2'b10
    } sps_op_e;
    typedef struct packed {
        logic [21:0] addr;
        logic [7:0] data;
    } sps_bus_s;
    typedef enum logic [3:0] {
        SPS_IDLE = 4'b0000,
        SPS_HWRST = 4'b0001,
        SPS_RAISE = 4'b0010,
        SPS_PPULSE = 4'b0011,
        SPS_PWAIT = 4'b0100,
        SPS_PVCMD = 4'b0101,
        SPS_PVREAD = 4'b0110,
        SPS_UPULSE = 4'b0111,
        SPS_UWAIT = 4'b1000,
        SPS_UVCMD = 4'b1001,
        SPS_UVREAD = 4'b1010,
        SPS_DROP = 4'b1011,
        SPS_RSTCMD = 4'b1100,
        SPS_FAIL = 4'b1101,
        SPS_DONE = 4'b1110
    } sps_state_e;
endpackage

/* sps_properties.sv */
`timescale 1ns/1ps
module sps_properties #(
    parameter int PROTECT_WAIT_CYC = 7500,
    parameter int UNPROTECT_COM_CYC = 750000,
    parameter int UNPROTECT_IND_CYC = 900000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic industrial,
    input wire logic [21:0] flashAddr,
    input wire logic [7:0] dqOut,
    input wire logic dqOe,
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic resetN,
    input wire logic resetElevated,
    input wire logic done,
    input wire logic failed,
    input wire logic [9:0] pulseAttemptCount
);
    logic [9:0] lowCnt, next_lowCnt;
    logic [7:0] elevCnt, next_elevCnt, lastCmd, next_lastCmd;
    logic [19:0] gapCnt, next_gapCnt;
    logic lastA6, next_lastA6;
    // counters saturate so long waits never wrap into a false pass
    always_comb begin
        next_lowCnt = resetN ? 10'h000 : lowCnt + {9'h000, lowCnt != 10'h3FF};
        next_elevCnt = resetElevated ? elevCnt + {7'h00, elevCnt != 8'hFF} : 8'h00;
        next_gapCnt = weN ? gapCnt + {19'h00000, gapCnt != 20'hFFFFF} : 20'h00000;
        next_lastCmd = weN ? lastCmd : dqOut;
        next_lastA6 = weN ? lastA6 : flashAddr[6];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt <= 10'h000;
            elevCnt <= 8'h00;
            gapCnt <= 20'h00000;
            lastCmd <= 8'h00;
            lastA6 <= 1'b0;
        end else begin
            lowCnt <= next_lowCnt;
            elevCnt <= next_elevCnt;
            gapCnt <= next_gapCnt;
            lastCmd <= next_lastCmd;
            lastA6 <= next_lastA6;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reset_low_width: assert property ($rose(resetN) |-> lowCnt >= 10'h019)
        else $error("reset pin released too early");
    a_quiet_in_reset: assert property (!resetN |-> ceN && weN && oeN)
        else $error("bus access while reset pin low");
    a_elevated_reset_high: assert property (resetElevated |-> resetN)
        else $error("elevated level with reset pin low");
    a_elevated_settle: assert property ($fell(weN) && resetElevated |-> elevCnt >= 8'h32)
        else $error("write too soon after elevated level");
    a_write_code: assert property ($fell(weN) && resetElevated |->
        (dqOut == 8'h60 || dqOut == 8'h40) && flashAddr[1:0] == 2'b10 && dqOe && oeN)
        else $error("bad command or address bits while elevated");
    a_protect_wait: assert property ($fell(weN) && resetElevated && dqOut == 8'h40
        && !flashAddr[6] && lastCmd == 8'h60 && !lastA6 |-> gapCnt >= PROTECT_WAIT_CYC)
        else $error("protect verify too early");
    a_unprotect_wait: assert property ($fell(weN) && resetElevated && dqOut == 8'h40
        && flashAddr[6] && lastCmd == 8'h60 && lastA6 |->
        gapCnt >= (industrial ? UNPROTECT_IND_CYC : UNPROTECT_COM_CYC))
        else $error("unprotect verify too early");
    a_protect_count: assert property ($fell(weN) && resetElevated && dqOut == 8'h60
        && !flashAddr[6] |-> pulseAttemptCount inside {[10'h001:10'h019]})
        else $error("protect pulse count out of range");
    a_unprotect_count: assert property ($fell(weN) && resetElevated && dqOut == 8'h60
        && flashAddr[6] |-> pulseAttemptCount inside {[10'h001:10'h3E8]})
        else $error("unprotect pulse count out of range");
    a_reset_command: assert property ($fell(resetElevated) |->
        ##[0:20] (failed || (!weN && dqOut == 8'hF0)))
        else $error("no reset command after elevated level");
    cover property ($rose(failed));
    cover property ($fell(weN) && resetElevated && flashAddr[6] && dqOut == 8'h60);
    cover property ($rose(resetN));
    cover property (done && !failed);
endmodule
bind sector_protect_sequencer sps_properties #(
    .PROTECT_WAIT_CYC(PROTECT_WAIT_CYC),
    .UNPROTECT_COM_CYC(UNPROTECT_COM_CYC),
    .UNPROTECT_IND_CYC(UNPROTECT_IND_CYC)
) chk (.clk(clk), .rst_n(rst_n), .industrial(industrial), .flashAddr(flashAddr),
    .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN), .oeN(oeN), .weN(weN), .resetN(resetN),
    .resetElevated(resetElevated), .done(done), .failed(failed),
    .pulseAttemptCount(pulseAttemptCount));
